//--- rtl/gsd_consts.vh
`ifndef GSD_CONSTS_VH
`define GSD_CONSTS_VH

// ****************************************
// Doubleword 0 fields
// ****************************************
`define GSD_CLASS_MSB      4
`define GSD_CLASS_LSB      0
`define GSD_CLASS_MEM      5'h02
`define GSD_SUBOP_MSB      10
`define GSD_SUBOP_LSB      8
`define GSD_SUBOP_SHARED   3'h4
`define GSD_SUBOP_TESS     3'h5
`define GSD_SRC_MSB        17
`define GSD_SRC_LSB        11
`define GSD_SRM_MSB        19
`define GSD_SRM_LSB        18
`define GSD_SELX_LSB       20
`define GSD_SELY_LSB       23
`define GSD_SELZ_LSB       26

// ****************************************
// Doubleword 1 fields
// ****************************************
`define GSD_DST_MSB        6
`define GSD_DST_LSB        0
`define GSD_DRM_MSB        8
`define GSD_DRM_LSB        7
`define GSD_OP_MSB         14
`define GSD_OP_LSB         9
`define GSD_OFS_MSB        22
`define GSD_OFS_LSB        16
`define GSD_BCAST_BIT      31

// ****************************************
// Encodings
// ****************************************
`define GSD_NO_OFFSET_MODE       2'h0
`define GSD_LOOP_INDEX_OFFSET_MODE       2'h1
`define GSD_REL_ABS        2'h2
`define GSD_SEL_X          3'h0
`define GSD_SEL_Y          3'h1
`define GSD_SEL_Z          3'h2
`define GSD_SEL_W          3'h3
`define GSD_SEL_ZERO       3'h4
`define GSD_SEL_ONE        3'h5
`define GSD_FLOAT_ONE      32'h3f800000
`define GSD_SCALE_SHIFT    6

`define GSD_OP_ADD         6'h00
`define GSD_OP_SUB         6'h01
`define GSD_OP_RSUB        6'h02
`define GSD_OP_INC         6'h03
`define GSD_OP_DEC         6'h04
`define GSD_OP_MIN_S       6'h05
`define GSD_OP_MAX_S       6'h06
`define GSD_OP_MIN_U       6'h07
`define GSD_OP_MAX_U       6'h08
`define GSD_OP_AND         6'h09
`define GSD_OP_OR          6'h0a
`define GSD_OP_XOR         6'h0b
`define GSD_OP_MSKOR       6'h0c
`define GSD_OP_WRITE       6'h0d
`define GSD_OP_WREL        6'h0e
`define GSD_OP_W2          6'h0f
`define GSD_OP_CMP         6'h10
`define GSD_OP_CMP_SPF     6'h11
`define GSD_OP_BYTE        6'h12

`endif

//--- rtl/gsd_atomic_alu.v
`timescale 1ns/1ps
`include "gsd_consts.vh"

// ****************************************
// Atomic read-modify-write arithmetic
// ****************************************
module gsd_atomic_alu #(
  parameter DATA_W = 32
) (
  // Operands
  input  wire [5:0]        op_i,
  input  wire [DATA_W-1:0] mem_i,
  input  wire [DATA_W-1:0] src_i,
  input  wire [DATA_W-1:0] aux_i,
  // Result
  output reg  [DATA_W-1:0] res_o,
  output reg               wr_o
);

  wire signed [DATA_W-1:0] mem_s = mem_i;
  wire signed [DATA_W-1:0] src_s = src_i;

  always @* begin
    res_o = mem_i;
    wr_o  = 1'b1;
    case (op_i)
      `GSD_OP_ADD:  res_o = mem_i + src_i;
      `GSD_OP_SUB:  res_o = mem_i - src_i;
      `GSD_OP_RSUB: res_o = src_i - mem_i;
      `GSD_OP_INC:  res_o = (mem_i >= src_i) ? {DATA_W{1'b0}} : mem_i + {{(DATA_W-1){1'b0}}, 1'b1};
      `GSD_OP_DEC:  res_o = ((mem_i == {DATA_W{1'b0}}) || (mem_i > src_i)) ? src_i :
                            mem_i - {{(DATA_W-1){1'b0}}, 1'b1};
      `GSD_OP_MIN_S: res_o = (mem_s < src_s) ? mem_i : src_i;
      `GSD_OP_MAX_S: res_o = (mem_s > src_s) ? mem_i : src_i;
      `GSD_OP_MIN_U: res_o = (mem_i < src_i) ? mem_i : src_i;
      `GSD_OP_MAX_U: res_o = (mem_i > src_i) ? mem_i : src_i;
      `GSD_OP_AND:  res_o = mem_i & src_i;
      `GSD_OP_OR:   res_o = mem_i | src_i;
      `GSD_OP_XOR:  res_o = mem_i ^ src_i;
      `GSD_OP_MSKOR: res_o = (mem_i & ~aux_i) | src_i;
      `GSD_OP_WRITE, `GSD_OP_WREL, `GSD_OP_W2: res_o = src_i;
      `GSD_OP_BYTE: res_o = {{(DATA_W-8){1'b0}}, src_i[7:0]};
      `GSD_OP_CMP, `GSD_OP_CMP_SPF: begin
        res_o = src_i;
        wr_o  = (mem_i == aux_i);
      end
      default: wr_o = 1'b0;
    endcase
  end

endmodule // gsd_atomic_alu

//--- rtl/gsd_decode.v
`timescale 1ns/1ps
`include "gsd_consts.vh"

// What this block does
// - Class field must equal memory class 2
// - Sub-opcode 4 shared, 5 tessellation write
// - Source index names write data register
// - Source mode: none, loop offset, absolute
// - Lane selectors pick XYZW, 0.0, 1.0
// - Result index receives returned data lanes
// - Result mode encodes like source mode
// - Opcode selects atomic, ignored for tessellation
// - Ops 0-2 add, subtract, reverse subtract
// - Op 3 wrapping increment against source
// - Op 4 wrapping decrement loading source
// - Ops 5-8 signed, unsigned min/max
// - Ops 9-11 AND, OR, XOR
// - Op 12 clear masked bits, OR source
// - Op 13 unconditional write
// - Op 14 second word at pair offset
// - Op 15 second word at 64x offset
// - Ops 16,17 compare and store
// - Op 18 stores low byte, upper bytes zeroed
// - Dword 1 bits 22:16 give offset
// - Broadcast: first active pixel only
module gsd_decode #(
  parameter DATA_W  = 32,
  parameter ADDR_W  = 10,
  parameter PIXELS  = 4
) (
  // Clock and reset
  input  wire                clock_i,
  input  wire                reset_i,
  // Instruction issue
  input  wire                issue_valid_i,
  input  wire [31:0]         issue_word0_i,
  input  wire [31:0]         issue_word1_i,
  input  wire                shared_clause_issue_i,
  // Issue context
  input  wire [6:0]          loop_index_i,
  input  wire [6:0]          thread_base_i,
  input  wire [ADDR_W-1:0]   base_addr_i,
  input  wire [ADDR_W-1:0]   pair_index_offset_i,
  input  wire [PIXELS-1:0]   active_mask_i,
  // Source register file read data
  input  wire [4*DATA_W-1:0] src_data_i,
  // Shared memory read data
  input  wire [DATA_W-1:0]   mem_rdata_i,
  // Register addresses
  output reg  [6:0]          src_addr_o,
  output reg  [6:0]          dst_addr_o,
  // Decoded status
  output reg                 tess_factor_store_o,
  output reg                 illegal_o,
  output reg  [PIXELS-1:0]   pixel_mask_o,
  output reg                 broadcast_o,
  // Tessellation write data
  output reg  [DATA_W-1:0]   tess_index_o,
  output reg  [DATA_W-1:0]   tess_lod_o,
  // Shared memory port
  output reg  [ADDR_W-1:0]   mem_addr_o,
  output reg                 mem_rd_o,
  output reg                 mem_we_o,
  output reg  [DATA_W-1:0]   mem_wdata_o,
  // Progress
  output reg                 busy_o,
  output reg                 done_o
);

  // ****************************************
  // Functions
  // ****************************************
  // Lane code to lane value
  function [DATA_W-1:0] lane_pick;
    input [2:0]          sel;
    input [4*DATA_W-1:0] vec;
    begin
      case (sel)
        `GSD_SEL_X:    lane_pick = vec[DATA_W-1:0];
        `GSD_SEL_Y:    lane_pick = vec[2*DATA_W-1:DATA_W];
        `GSD_SEL_Z:    lane_pick = vec[3*DATA_W-1:2*DATA_W];
        `GSD_SEL_W:    lane_pick = vec[4*DATA_W-1:3*DATA_W];
        `GSD_SEL_ZERO: lane_pick = {DATA_W{1'b0}};
        `GSD_SEL_ONE:  lane_pick = `GSD_FLOAT_ONE;
        default: lane_pick = {DATA_W{1'b0}};
      endcase
    end
  endfunction

  // Register index wraps at 128, mode 3 acts as mode 0
  function [6:0] rel_addr;
    input [6:0] idx;
    input [1:0] mode;
    input [6:0] loop_idx;
    input [6:0] base;
    reg   [8:0] sum;
    begin
      case (mode)
        `GSD_LOOP_INDEX_OFFSET_MODE: sum = {2'b00, idx} + {2'b00, loop_idx} + {2'b00, base};
        `GSD_REL_ABS:  sum = {2'b00, idx};
        default:       sum = {2'b00, idx} + {2'b00, base};
      endcase
      rel_addr = sum[6:0];
    end
  endfunction

  function sel_bad;
    input [2:0] sel;
    begin
      sel_bad = (sel > `GSD_SEL_ONE);
    end
  endfunction

  // ****************************************
  // Field extraction
  // ****************************************
  // Doubleword 0
  wire [4:0] class_f   = issue_word0_i[`GSD_CLASS_MSB:`GSD_CLASS_LSB];
  wire [2:0] subop_f   = issue_word0_i[`GSD_SUBOP_MSB:`GSD_SUBOP_LSB];
  wire [6:0] src_f     = issue_word0_i[`GSD_SRC_MSB:`GSD_SRC_LSB];
  wire [1:0] srm_f     = issue_word0_i[`GSD_SRM_MSB:`GSD_SRM_LSB];
  wire [2:0] selx_f    = issue_word0_i[`GSD_SELX_LSB+2:`GSD_SELX_LSB];
  wire [2:0] sely_f    = issue_word0_i[`GSD_SELY_LSB+2:`GSD_SELY_LSB];
  wire [2:0] selz_f    = issue_word0_i[`GSD_SELZ_LSB+2:`GSD_SELZ_LSB];

  // Doubleword 1
  wire [6:0] dst_f     = issue_word1_i[`GSD_DST_MSB:`GSD_DST_LSB];
  wire [1:0] drm_f     = issue_word1_i[`GSD_DRM_MSB:`GSD_DRM_LSB];
  wire [5:0] op_f      = issue_word1_i[`GSD_OP_MSB:`GSD_OP_LSB];
  wire [6:0] ofs_f     = issue_word1_i[`GSD_OFS_MSB:`GSD_OFS_LSB];
  wire       bcast_f   = issue_word1_i[`GSD_BCAST_BIT];

  // ****************************************
  // Legality checks
  // ****************************************
  // class check
  wire class_ok = (class_f == `GSD_CLASS_MEM);
  // sub-opcode check, must agree with issue
  wire is_shared = (subop_f == `GSD_SUBOP_SHARED);
  wire is_tess   = (subop_f == `GSD_SUBOP_TESS);
  wire subop_ok  = (is_shared | is_tess) & shared_clause_issue_i;
  wire sel_ok    = ~sel_bad(selx_f) &
                   ~sel_bad(sely_f) &
                   ~sel_bad(selz_f);
  wire illegal   = ~(class_ok & subop_ok & sel_ok);

  // ****************************************
  // State machine
  // ****************************************
  localparam [3:0] ST_IDLE  = 4'h1;
  localparam [3:0] ST_READ  = 4'h2;
  localparam [3:0] ST_WRITE = 4'h4;
  localparam [3:0] ST_PAIR  = 4'h8;

  reg [3:0]        state_reg;
  reg [3:0]        state_next;
  reg [5:0]        op_reg;
  reg [DATA_W-1:0] op_a_reg;
  reg [DATA_W-1:0] op_b_reg;
  reg [DATA_W-1:0] op_c_reg;
  reg [ADDR_W-1:0] addr_reg;

  // ****************************************
  // Atomic arithmetic
  // ****************************************
  wire [DATA_W-1:0] alu_res;
  wire              alu_wr;

  gsd_atomic_alu #(
    .DATA_W (DATA_W)
  ) u_alu (
    .op_i  (op_reg),
    .mem_i (mem_rdata_i),
    .src_i (op_b_reg),
    .aux_i (op_a_reg),
    .res_o (alu_res),
    .wr_o  (alu_wr)
  );

  // ****************************************
  // Operand and address selection
  // ****************************************
  // Masked-or and compare: X is mask or compare, Z is source
  wire two_src_op = (op_f == `GSD_OP_MSKOR) ||
                    (op_f == `GSD_OP_CMP) ||
                    (op_f == `GSD_OP_CMP_SPF);
  wire pair_op    = (op_f == `GSD_OP_WREL) ||
                    (op_f == `GSD_OP_W2);

  wire [ADDR_W-1:0] word_addr = base_addr_i + {{(ADDR_W-7){1'b0}}, ofs_f};
  wire [ADDR_W-1:0] pair_rel  = pair_index_offset_i;
  wire [ADDR_W-1:0] pair_w2   = pair_index_offset_i << `GSD_SCALE_SHIFT;
  wire [ADDR_W-1:0] pair_step = (op_reg == `GSD_OP_W2) ? pair_w2 : pair_rel;

  wire [DATA_W-1:0] lane_a = lane_pick(selx_f, src_data_i);
  wire [DATA_W-1:0] lane_b = lane_pick(sely_f, src_data_i);
  wire [DATA_W-1:0] lane_c = lane_pick(selz_f, src_data_i);

  // Lowest set bit of the active mask
  // first active pixel only
  wire [PIXELS-1:0] first_active = active_mask_i & (~active_mask_i + {{(PIXELS-1){1'b0}}, 1'b1});

  // ****************************************
  // Next-state logic
  // ****************************************
  // Issues while busy are dropped without a flag
  wire start_ok = issue_valid_i & (state_reg == ST_IDLE) & ~illegal;

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start_ok && is_shared)
          state_next = pair_op ? ST_PAIR : ST_READ;
      end
      ST_READ:  state_next = ST_WRITE;
      ST_WRITE: state_next = ST_IDLE;
      ST_PAIR:  state_next = ST_IDLE;
      default:  state_next = ST_IDLE;
    endcase
  end

  // State register
  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  // Operands held for the read-modify-write
  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      op_reg   <= 6'h00;
      op_a_reg <= {DATA_W{1'b0}};
      op_b_reg <= {DATA_W{1'b0}};
      op_c_reg <= {DATA_W{1'b0}};
      addr_reg <= {ADDR_W{1'b0}};
    end else if (start_ok) begin
      // opcode latched on every accepted issue, tessellation included
      op_reg   <= op_f;
      op_a_reg <= two_src_op ? lane_a : lane_b;
      op_b_reg <= two_src_op ? lane_c : lane_a;
      op_c_reg <= lane_b;
      addr_reg <= word_addr;
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      src_addr_o          <= 7'h00;
      dst_addr_o          <= 7'h00;
      tess_factor_store_o <= 1'b0;
      illegal_o           <= 1'b0;
      pixel_mask_o        <= {PIXELS{1'b0}};
      broadcast_o         <= 1'b0;
      tess_index_o        <= {DATA_W{1'b0}};
      tess_lod_o          <= {DATA_W{1'b0}};
      mem_addr_o          <= {ADDR_W{1'b0}};
      mem_rd_o            <= 1'b0;
      mem_we_o            <= 1'b0;
      mem_wdata_o         <= {DATA_W{1'b0}};
      busy_o              <= 1'b0;
      done_o              <= 1'b0;
    end else begin
      // Pulses default low each cycle
      mem_rd_o            <= 1'b0;
      mem_we_o            <= 1'b0;
      done_o              <= 1'b0;
      tess_factor_store_o <= 1'b0;
      illegal_o           <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (issue_valid_i) begin
            illegal_o  <= illegal;
            src_addr_o <= rel_addr(src_f, srm_f, loop_index_i, thread_base_i);
          end
          if (start_ok) begin
            dst_addr_o   <= rel_addr(dst_f, drm_f, loop_index_i, thread_base_i);
            broadcast_o  <= bcast_f;
            pixel_mask_o <= bcast_f ? first_active : active_mask_i;
            if (is_tess) begin
              tess_factor_store_o <= 1'b1;
              tess_index_o        <= lane_pick(`GSD_SEL_X, src_data_i);
              tess_lod_o          <= lane_pick(`GSD_SEL_Y, src_data_i);
              done_o              <= 1'b1;
            end else if (pair_op) begin
              mem_addr_o  <= word_addr;
              mem_wdata_o <= lane_a;
              mem_we_o    <= 1'b1;
              busy_o      <= 1'b1;
            end else begin
              mem_addr_o <= word_addr;
              mem_rd_o   <= 1'b1;
              busy_o     <= 1'b1;
            end
          end
        end
        ST_READ: begin
          // Address held while memory answers
          mem_addr_o <= addr_reg;
        end
        ST_WRITE: begin
          mem_addr_o  <= addr_reg;
          mem_wdata_o <= alu_res;
          mem_we_o    <= alu_wr;
          busy_o      <= 1'b0;
          done_o      <= 1'b1;
        end
        ST_PAIR: begin
          mem_addr_o  <= addr_reg + pair_step;
          mem_wdata_o <= op_c_reg;
          mem_we_o    <= 1'b1;
          busy_o      <= 1'b0;
          done_o      <= 1'b1;
        end
        default: busy_o <= 1'b0;
      endcase
    end
  end

endmodule // gsd_decode

//--- test/gsd_decode_checker.sv
`timescale 1ns/1ps
// ****************************************
// Port checker
// ****************************************
module gsd_decode_checker #(
  parameter DATA_W = 32,
  parameter ADDR_W = 10,
  parameter PIXELS = 4
) (
  // Clock, reset and issue
  input wire              clock_i,
  input wire              reset_i,
  input wire              issue_valid_i,
  input wire [31:0]       issue_word0_i,
  input wire              shared_clause_issue_i,
  // Observed outputs
  input wire              illegal_o,
  input wire              busy_o,
  input wire              done_o,
  input wire              mem_rd_o,
  input wire              mem_we_o,
  input wire [ADDR_W-1:0] mem_addr_o,
  input wire              tess_factor_store_o,
  input wire              broadcast_o,
  input wire [PIXELS-1:0] pixel_mask_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);
  wire take    = issue_valid_i && !busy_o;
  wire cls_ok  = issue_word0_i[4:0] == 5'h02;
  wire sub_ok  = issue_word0_i[10:8] == 3'h4 || issue_word0_i[10:8] == 3'h5;
  wire sel_bad = (&issue_word0_i[22:21]) || (&issue_word0_i[25:24]) || (&issue_word0_i[28:27]);
  wire all_ok  = cls_ok && sub_ok && !sel_bad && shared_clause_issue_i;
  property p_cls; take && !cls_ok |=> illegal_o; endproperty
  a_cls: assert property (p_cls) else $error("bad class not flagged");
  property p_sub; take && !sub_ok |=> illegal_o; endproperty
  a_sub: assert property (p_sub) else $error("reserved subop not flagged");
  property p_sel; take && sel_bad |=> illegal_o; endproperty
  a_sel: assert property (p_sel) else $error("reserved selector not flagged");
  property p_good; take && all_ok |=> !illegal_o; endproperty
  a_good: assert property (p_good) else $error("legal issue flagged");
  property p_quiet; illegal_o |-> !mem_rd_o && !mem_we_o && !done_o; endproperty
  a_quiet: assert property (p_quiet) else $error("illegal issue touched memory");
  property p_rd; mem_rd_o |=> !mem_we_o ##1 done_o; endproperty
  a_rd: assert property (p_rd) else $error("atomic not done two cycles after read");
  property p_adr; mem_rd_o |=> $stable(mem_addr_o); endproperty
  a_adr: assert property (p_adr) else $error("address moved during atomic");
  property p_pair; mem_we_o && !done_o |=> mem_we_o && done_o; endproperty
  a_pair: assert property (p_pair) else $error("pair second write missing");
  property p_tess; tess_factor_store_o |-> done_o && !mem_we_o && !mem_rd_o; endproperty
  a_tess: assert property (p_tess) else $error("tess store touched memory");
  property p_bc; mem_rd_o && broadcast_o |-> $countones(pixel_mask_o) <= 1; endproperty
  a_bc: assert property (p_bc) else $error("broadcast kept several pixels");
  c_tess: cover property (tess_factor_store_o);
  c_ill: cover property (illegal_o);
  c_pair: cover property (mem_we_o && !done_o);
  c_cmpf: cover property (mem_rd_o ##2 (done_o && !mem_we_o));
endmodule // gsd_decode_checker

bind gsd_decode gsd_decode_checker #(.DATA_W(DATA_W), .ADDR_W(ADDR_W), .PIXELS(PIXELS)) chk (.clock_i, .reset_i,
  .issue_valid_i, .issue_word0_i, .shared_clause_issue_i, .illegal_o, .busy_o, .done_o, .mem_rd_o, .mem_we_o,
  .mem_addr_o, .tess_factor_store_o, .broadcast_o, .pixel_mask_o);

//--- test/gsd_mem_model.sv
`timescale 1ns/1ps
// ****************************************
// Shared memory array, one cycle read
// ****************************************
module gsd_mem_model #(
  parameter ADDR_W = 10
) (
  input  wire              clock_i,
  input  wire [ADDR_W-1:0] addr_i,
  input  wire              we_i,
  input  wire [31:0]       wdata_i,
  output logic [31:0]      rdata_o
);
  logic [31:0] mem [0:(1<<ADDR_W)-1];
  initial begin
    for (int i = 0; i < (1 << ADDR_W); i++) mem[i] = i * 32'h9e3779b1;
  end
  always @(posedge clock_i) begin
    if (we_i) mem[addr_i] <= wdata_i;
    rdata_o <= mem[addr_i];
  end
endmodule // gsd_mem_model

//--- test/global_share_op_decode_tb.sv
`timescale 1ns/1ps
module global_share_op_decode_tb;
  localparam AW = 10;
  logic clock_i, reset_i, issue_valid_i, shared_clause_issue_i, tess_factor_store_o, illegal_o, broadcast_o;
  logic mem_rd_o, mem_we_o, busy_o, done_o, bc, tess, wr;
  logic [31:0] issue_word0_i, issue_word1_i, mem_rdata_i, tess_index_o, tess_lod_o, mem_wdata_o;
  logic [31:0] rnd, lx, ly, lz, val, sh [0:1023], e_d [0:1];
  logic [6:0] loop_index_i, thread_base_i, src_addr_o, dst_addr_o, ofs, sidx, didx, e_sa, e_da;
  logic [AW-1:0] base_addr_i, pair_index_offset_i, mem_addr_o, addr, e_a [0:1];
  logic [3:0] active_mask_i, pixel_mask_o, e_pm;
  logic [127:0] src_data_i;
  logic [5:0] op;
  logic [1:0] srm, drm;
  logic [8:0] sel9;
  int failures, check_count, e_lat, e_nw, i, k;
  logic [31:0] bad0 [0:6] = '{32'h08800403, 32'h08800602, 32'h08800002, 32'h08e00402, 32'h0b800402,
                              32'h1c800402, 32'h08800402};

  gsd_decode #(.DATA_W(32), .ADDR_W(AW), .PIXELS(4)) DUT (.clock_i, .reset_i, .issue_valid_i, .issue_word0_i,
    .issue_word1_i, .shared_clause_issue_i, .loop_index_i, .thread_base_i, .base_addr_i, .pair_index_offset_i,
    .active_mask_i, .src_data_i, .mem_rdata_i, .src_addr_o, .dst_addr_o, .tess_factor_store_o, .illegal_o,
    .pixel_mask_o, .broadcast_o, .tess_index_o, .tess_lod_o, .mem_addr_o, .mem_rd_o, .mem_we_o, .mem_wdata_o,
    .busy_o, .done_o);
  gsd_mem_model #(.ADDR_W(AW)) MEM (.clock_i, .addr_i(mem_addr_o), .we_i(mem_we_o), .wdata_i(mem_wdata_o),
    .rdata_o(mem_rdata_i));

  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end

  function automatic [31:0] lfsr(input [31:0] x);
    lfsr = (x >> 1) ^ (x[0] ? 32'h80200003 : 32'h0);
  endfunction
  function automatic [6:0] rel(input [6:0] idx, input [1:0] m);
    rel = (m == 2'h2) ? idx : (m == 2'h1) ? idx + loop_index_i + thread_base_i : idx + thread_base_i;
  endfunction
  // ****************************************
  // Expected atomic result {write, value}
  // ****************************************
  function automatic [32:0] alu(input [5:0] o, input [31:0] m, input [31:0] s, input [31:0] a);
    case (o)
      0: alu = {1'b1, m + s};
      1: alu = {1'b1, m - s};
      2: alu = {1'b1, s - m};
      3: alu = {1'b1, (m >= s) ? 32'h0 : m + 1};
      4: alu = {1'b1, (m == 0 || m > s) ? s : m - 1};
      5: alu = {1'b1, ($signed(m) < $signed(s)) ? m : s};
      6: alu = {1'b1, ($signed(m) > $signed(s)) ? m : s};
      7: alu = {1'b1, (m < s) ? m : s};
      8: alu = {1'b1, (m > s) ? m : s};
      9: alu = {1'b1, m & s};
      10: alu = {1'b1, m | s};
      11: alu = {1'b1, m ^ s};
      12: alu = {1'b1, (m & ~a) | s};
      13: alu = {1'b1, s};
      16, 17: alu = (m == a) ? {1'b1, s} : {1'b0, m};
      18: alu = {1'b1, 24'h0, s[7:0]};
      default: alu = {1'b0, m};
    endcase
  endfunction

  task check(input [31:0] seen, input [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task close_out;
    if (failures == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task issue(input [31:0] w0, input [31:0] w1);
    @(negedge clock_i);
    issue_word0_i = w0;
    issue_word1_i = w1;
    issue_valid_i = 1'b1;
    @(negedge clock_i);
    issue_valid_i = 1'b0;
  endtask
  // ****************************************
  // Follow one operation to done
  // ****************************************
  task run(input junk);
    int n, nw;
    logic [AW-1:0] wa [0:1];
    logic [31:0] wd [0:1];
    nw = 0;
    check(src_addr_o, e_sa);
    if (!tess) check(dst_addr_o, e_da);
    if (!tess) check(pixel_mask_o, e_pm);
    if (!tess) check(broadcast_o, bc);
    check(mem_rd_o, e_lat == 3);
    check(busy_o, !tess);
    for (n = 1; n < 8; n++) begin
      if (mem_we_o && nw < 2) begin
        wa[nw] = mem_addr_o;
        wd[nw] = mem_wdata_o;
        nw++;
      end
      if (done_o) break;
      issue_valid_i = junk && n == 1;
      if (junk) issue_word0_i = 32'h0;
      @(negedge clock_i);
      check(illegal_o, 1'b0);
    end
    if (n == 8) begin
      failures++;
      close_out;
    end
    check(n, e_lat);
    check(busy_o, 1'b0);
    check(nw, e_nw);
    for (int j = 0; j < nw; j++) begin
      check(wa[j], e_a[j]);
      check(wd[j], e_d[j]);
    end
    for (int j = 0; j < e_nw; j++) sh[e_a[j]] = e_d[j];
  endtask

  initial begin
    {issue_valid_i, issue_word0_i, issue_word1_i, loop_index_i, thread_base_i, base_addr_i} = '0;
    {pair_index_offset_i, active_mask_i, src_data_i, failures, check_count} = '0;
    shared_clause_issue_i = 1'b1;
    reset_i = 1'b1;
    rnd = 32'hd25a;
    for (i = 0; i < 1024; i++) sh[i] = i * 32'h9e3779b1;
    repeat (3) @(negedge clock_i);
    reset_i = 1'b0;
    for (i = 0; i < 80; i++) begin
      rnd = lfsr(rnd);
      {drm, srm, active_mask_i, base_addr_i, thread_base_i, loop_index_i} = rnd;
      rnd = lfsr(rnd);
      {pair_index_offset_i, bc, didx, sidx, ofs} = rnd[31:0];
      rnd = lfsr(rnd);
      lx = rnd;
      rnd = lfsr(rnd);
      ly = rnd;
      rnd = lfsr(rnd);
      lz = rnd;
      op = (i < 19) ? i[5:0] : 6'(rnd[13:8] % 19);
      tess = i >= 66 && i[0];
      addr = base_addr_i + AW'(ofs);
      if (i % 3 == 0) lx = sh[addr];
      src_data_i = {rnd, lz, ly, lx};
      sel9 = 9'h088;
      if (i % 7 == 3 && !tess) {sel9, ly, lz} = {9'h128, 32'h3f800000, 32'h0};
      e_sa = rel(sidx, srm);
      e_da = rel(didx, drm);
      e_pm = bc ? active_mask_i & (~active_mask_i + 4'h1) : active_mask_i;
      if (tess) {e_lat, e_nw} = {32'd1, 32'd0};
      else if (op == 14 || op == 15) begin
        {e_lat, e_nw} = {32'd2, 32'd2};
        {e_a[0], e_d[0], e_d[1]} = {addr, lx, ly};
        e_a[1] = addr + ((op == 15) ? pair_index_offset_i << 6 : pair_index_offset_i);
      end else begin
        {wr, val} = alu(op, sh[addr], (op == 12 || op == 16 || op == 17) ? lz : lx, lx);
        {e_lat, e_nw, e_a[0], e_d[0]} = {32'd3, 31'd0, wr, addr, val};
      end
      issue({3'h0, sel9, srm, sidx, tess ? 3'h5 : 3'h4, 3'h0, 5'h02}, {bc, 8'h0, ofs, 1'b0, op, drm, didx});
      run(i % 5 == 1 && e_lat == 3);
      if (tess) begin
        check(tess_factor_store_o, 1'b1);
        check(tess_index_o, lx);
        check(tess_lod_o, ly);
      end
    end
    for (k = 0; k < 7; k++) begin
      shared_clause_issue_i = k != 6;
      issue(bad0[k], 32'h0);
      check(illegal_o, 1'b1);
      check({mem_rd_o, mem_we_o, done_o}, 3'h0);
      @(negedge clock_i);
      check(illegal_o, 1'b0);
    end
    close_out;
  end
endmodule // global_share_op_decode_tb
